// [hw/usb_irq_params.svh]
// Register offsets, field positions and reset values of the enable and select bank
`ifndef USB_IRQ_PARAMS_SVH
`define USB_IRQ_PARAMS_SVH

// Byte addresses on the register port
`define IEN_OFFSET        8'h14
`define STS_OFFSET        8'h18
`define MODE_OFFSET       8'h40
`define EPS_OFFSET        8'h2c

// Interrupt enable mask layout
`define IEN_RESET         32'h00000000
`define IEN_WMASK         32'h03fffdff
`define IEN_BUSRST_KEEP   32'h00000001
`define IEN_BRST_BIT      0
`define IEN_SOF_BIT       1
`define IEN_PSOF_BIT      2
`define IEN_SUSP_BIT      3
`define IEN_RESM_BIT      4
`define IEN_HS_BIT        5
`define IEN_DMA_BIT       6
`define IEN_VBUS_BIT      7
`define IEN_SETUP_BIT     8
`define IEN_CTRL_OUT_BIT  10
`define IEN_CTRL_IN_BIT   11
`define IEN_DATA_LO_BIT   12
`define DATA_EP_COUNT     7

// Endpoint selection layout
`define EPS_RESET         8'h00
`define EPS_WMASK         8'h3f
`define EPS_DIR_BIT       0
`define EPS_NUM_LO_BIT    1
`define EPS_NUM_HI_BIT    4
`define EPS_SETUP_BIT     5

// Mode register of the bank
`define MODE_RESET        1'b0
`define MODE_GLOBAL_BIT   0

// Read data zero fill
`define RDATA_ZERO        32'h00000000

`endif

// [hw/usb_irq_pkg.sv]
// Types shared by the enable and select bank
package usb_irq_pkg;

    typedef logic [31:0] word_type;
    typedef logic [7:0]  addr_type;

    // Register addressed by the current strobe
    typedef enum logic [2:0]
    {
        sel_none = 3'b000,
        sel_ien  = 3'b001,
        sel_sts  = 3'b010,
        sel_mode = 3'b011,
        sel_eps  = 3'b100
    } reg_sel_type;

endpackage : usb_irq_pkg

// [hw/irq_event_latch.sv]
// Sticky interrupt sources gated by the enable mask and the global enable
`timescale 1ns/1ns
`include "usb_irq_params.svh"

module irq_event_latch
(
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    input  wire usb_irq_pkg::word_type src_event,
    input  wire usb_irq_pkg::word_type src_enable,
    input  wire logic                 global_enable,
    input  wire usb_irq_pkg::word_type clear_mask,
    input  wire logic                 clear_strobe,
    output usb_irq_pkg::word_type     pending,
    output logic                      irq_out
);

    usb_irq_pkg::word_type next_pending;
    logic                  next_irq;

    // Set wins over a same-cycle clear so no mapped event is ever dropped
    always_comb
    begin
        next_pending = pending;
        if (clear_strobe)
        begin
            next_pending = next_pending & ~clear_mask;
        end
        next_pending = (next_pending | src_event) & `IEN_WMASK;
        next_irq     = global_enable & (|(pending & src_enable));
    end

    // Registered output keeps the pin glitch free
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            pending <= `IEN_RESET;
            irq_out <= 1'b0;
        end
        else
        begin
            pending <= next_pending;
            irq_out <= next_irq;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_global_off;
        !global_enable |=> !irq_out;
    endproperty
    a_global_off: assert property (p_global_off)
        else $error("irq asserted while global enable off");

    property p_irq_cause;
        irq_out |-> $past(global_enable) && (|($past(pending) & $past(src_enable)));
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("irq asserted without an enabled pending source");

    // Every mapped event must be latched at the next edge, even beside a clear
    property p_set_wins;
        (src_event & `IEN_WMASK) != `IEN_RESET
            |=> (pending & $past(src_event) & `IEN_WMASK) == ($past(src_event) & `IEN_WMASK);
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("source event lost against a clear");

    c_irq_rise: cover property ($rose(irq_out));

endmodule : irq_event_latch

// [hw/usb_irq_enable_endpoint_select.sv]
// Interrupt enable mask, endpoint selection and mode registers of the USB controller
`timescale 1ns/1ns
`include "usb_irq_params.svh"

module usb_irq_enable_endpoint_select
(
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    input  wire usb_irq_pkg::addr_type reg_addr,
    input  wire usb_irq_pkg::word_type reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output usb_irq_pkg::word_type      reg_rdata,
    input  wire logic                  usb_bus_reset,
    input  wire usb_irq_pkg::word_type irq_source_event,
    output usb_irq_pkg::word_type      irq_source_enable,
    output logic                       global_irq_enable,
    output logic                       irq_out,
    output logic [3:0]                 endpoint_number,
    output logic                       endpoint_dir,
    output logic                       setup_buffer_select,
    output logic [6:0]                 data_out_irq_en,
    output logic [6:0]                 data_in_irq_en,
    output logic                       ctrl_in_irq_en,
    output logic                       ctrl_out_irq_en,
    output logic                       ctrl_setup_irq_en,
    output logic                       supply_sense_irq_en,
    output logic                       transfer_engine_irq_en,
    output logic                       speed_change_irq_en,
    output logic                       wakeup_irq_en,
    output logic                       sleep_irq_en,
    output logic                       synthetic_frame_irq_en,
    output logic                       frame_start_irq_en,
    output logic                       bus_reset_irq_en
);

    usb_irq_pkg::reg_sel_type sel;
    usb_irq_pkg::word_type    ien;
    usb_irq_pkg::word_type    next_ien;
    logic [7:0]               eps;
    logic [7:0]               next_eps;
    logic                     mode_global;
    logic                     next_mode_global;
    usb_irq_pkg::word_type    next_rdata;
    usb_irq_pkg::word_type    pending;
    logic                     sts_clear;

    // Address decode shared by reads and writes
    always_comb
    begin
        case (reg_addr)
            `IEN_OFFSET:  sel = usb_irq_pkg::sel_ien;
            `STS_OFFSET:  sel = usb_irq_pkg::sel_sts;
            `MODE_OFFSET: sel = usb_irq_pkg::sel_mode;
            `EPS_OFFSET:  sel = usb_irq_pkg::sel_eps;
            default:      sel = usb_irq_pkg::sel_none;
        endcase
    end

    // Next register values; bus reset is applied after a same-cycle write
    // because hardware must leave the mask clean once the bus resets; bit 0, the bus reset enable, is kept
    always_comb
    begin
        next_ien         = ien;
        next_eps         = eps;
        next_mode_global = mode_global;
        if (reg_wr && (sel == usb_irq_pkg::sel_ien))
        begin
            next_ien = reg_wdata & `IEN_WMASK;
        end
        if (reg_wr && (sel == usb_irq_pkg::sel_eps))
        begin
            next_eps = reg_wdata[7:0] & `EPS_WMASK;
        end
        if (reg_wr && (sel == usb_irq_pkg::sel_mode))
        begin
            next_mode_global = reg_wdata[`MODE_GLOBAL_BIT];
        end
        if (usb_bus_reset)
        begin
            next_ien = next_ien & `IEN_BUSRST_KEEP;
            next_eps = `EPS_RESET;
        end
    end

    // Read mux; unmapped addresses return zero, reserved bits stay zero
    always_comb
    begin
        next_rdata = `RDATA_ZERO;
        if (reg_rd)
        begin
            case (sel)
                usb_irq_pkg::sel_ien:  next_rdata = ien;
                usb_irq_pkg::sel_sts:  next_rdata = pending;
                usb_irq_pkg::sel_mode: next_rdata = {31'h00000000, mode_global};
                usb_irq_pkg::sel_eps:  next_rdata = {24'h000000, eps};
                default:               next_rdata = `RDATA_ZERO;
            endcase
        end
    end

    // Register stage
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            ien         <= `IEN_RESET;
            eps         <= `EPS_RESET;
            mode_global <= `MODE_RESET;
            reg_rdata   <= `RDATA_ZERO;
        end
        else
        begin
            ien         <= next_ien;
            eps         <= next_eps;
            mode_global <= next_mode_global;
            reg_rdata   <= next_rdata;
        end
    end

    // Write one to clear on the status register
    assign sts_clear = reg_wr && (sel == usb_irq_pkg::sel_sts);

    irq_event_latch u_latch
    (
        .mclk          (mclk),
        .rst_n         (rst_n),
        .src_event     (irq_source_event),
        .src_enable    (ien),
        .global_enable (mode_global),
        .clear_mask    (reg_wdata),
        .clear_strobe  (sts_clear),
        .pending       (pending),
        .irq_out       (irq_out)
    );

    // Selection fields steer the indexed register path; the selection
    // does not guard against SETUP set on other endpoints, firmware must
    assign endpoint_number     = eps[`EPS_NUM_HI_BIT:`EPS_NUM_LO_BIT];
    assign endpoint_dir        = eps[`EPS_DIR_BIT];
    assign setup_buffer_select = eps[`EPS_SETUP_BIT];
    assign irq_source_enable   = ien;
    assign global_irq_enable   = mode_global;

    // Per data endpoint enables, RX at the even bit and TX just above
    genvar gi;
    generate
        for (gi = 0; gi < `DATA_EP_COUNT; gi = gi + 1)
        begin : g_data_ep
            assign data_out_irq_en[gi] = ien[`IEN_DATA_LO_BIT + 2 * gi];
            assign data_in_irq_en[gi]  = ien[`IEN_DATA_LO_BIT + 2 * gi + 1];
        end
    endgenerate

    // Individual enables of endpoint 0 and bus events
    assign ctrl_in_irq_en         = ien[`IEN_CTRL_IN_BIT];
    assign ctrl_out_irq_en        = ien[`IEN_CTRL_OUT_BIT];
    assign ctrl_setup_irq_en      = ien[`IEN_SETUP_BIT];
    assign supply_sense_irq_en    = ien[`IEN_VBUS_BIT];
    assign transfer_engine_irq_en = ien[`IEN_DMA_BIT];
    assign speed_change_irq_en    = ien[`IEN_HS_BIT];
    assign wakeup_irq_en          = ien[`IEN_RESM_BIT];
    assign sleep_irq_en           = ien[`IEN_SUSP_BIT];
    assign synthetic_frame_irq_en = ien[`IEN_PSOF_BIT];
    assign frame_start_irq_en     = ien[`IEN_SOF_BIT];
    assign bus_reset_irq_en       = ien[`IEN_BRST_BIT];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // Helpers: write to the mask or to the selection in a cycle without bus reset
    logic ien_wr_clean;
    logic eps_wr_clean;
    assign ien_wr_clean = reg_wr && (sel == usb_irq_pkg::sel_ien) && !usb_bus_reset;
    assign eps_wr_clean = reg_wr && (sel == usb_irq_pkg::sel_eps) && !usb_bus_reset;

    property p_ien_write;
        ien_wr_clean |=> (ien == ($past(reg_wdata) & `IEN_WMASK));
    endproperty
    a_ien_write: assert property (p_ien_write)
        else $error("enable mask did not take the written value");

    property p_reserved_zero;
        (ien & ~`IEN_WMASK) == `IEN_RESET;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved enable bit set");

    property p_busrst_clear;
        usb_bus_reset |=> ((ien & ~`IEN_BUSRST_KEEP) == `IEN_RESET) && (eps == `EPS_RESET);
    endproperty
    a_busrst_clear: assert property (p_busrst_clear)
        else $error("bus reset left an enable or selection set");

    property p_busrst_keep;
        usb_bus_reset && !(reg_wr && (sel == usb_irq_pkg::sel_ien))
            |=> bus_reset_irq_en == $past(bus_reset_irq_en);
    endproperty
    a_busrst_keep: assert property (p_busrst_keep)
        else $error("bus reset changed the bus reset enable");

    property p_eps_number;
        eps_wr_clean |=> endpoint_number == $past(reg_wdata[4:1]);
    endproperty
    a_eps_number: assert property (p_eps_number)
        else $error("endpoint number not taken from write");

    property p_eps_dir;
        eps_wr_clean |=> endpoint_dir == $past(reg_wdata[0]);
    endproperty
    a_eps_dir: assert property (p_eps_dir)
        else $error("direction not taken from write");

    property p_eps_setup;
        eps_wr_clean |=> setup_buffer_select == $past(reg_wdata[5]);
    endproperty
    a_eps_setup: assert property (p_eps_setup)
        else $error("setup select not taken from write");

    property p_hw_reset;
        $past(rst_n) == 1'b0 |-> (ien == `IEN_RESET) && (eps == `EPS_RESET);
    endproperty
    a_hw_reset: assert property (p_hw_reset)
        else $error("registers not cleared by hardware reset");

    property p_eps_read;
        reg_rd && (sel == usb_irq_pkg::sel_eps) |=> reg_rdata == {24'h000000, $past(eps)};
    endproperty
    a_eps_read: assert property (p_eps_read)
        else $error("selection read back wrong");

    property p_global_gate;
        !global_irq_enable ##1 !global_irq_enable |-> !irq_out;
    endproperty
    a_global_gate: assert property (p_global_gate)
        else $error("interrupt while global enable off");

    c_busrst_mask: cover property (usb_bus_reset && (ien != `IEN_RESET));
    c_setup_sel:   cover property (eps_wr_clean && reg_wdata[5]);
    c_irq:         cover property (global_irq_enable && irq_out);

endmodule : usb_irq_enable_endpoint_select

// [dv/mcu_model.sv]
// Microcontroller model that drives the register port of the bank
`timescale 1ns/1ns
module mcu_model
(
    input  wire logic                  mclk,
    output usb_irq_pkg::addr_type      reg_addr,
    output usb_irq_pkg::word_type      reg_wdata,
    output logic                       reg_wr,
    output logic                       reg_rd,
    input  wire usb_irq_pkg::word_type reg_rdata
);
    // Idle bus with both strobes low
    initial
    begin
        reg_addr  = 8'h00;
        reg_wdata = 32'h00000000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // One-cycle write; data is inverted once released so stale values never look valid
    task automatic bus_write(input usb_irq_pkg::addr_type a, input usb_irq_pkg::word_type d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
    endtask : bus_write

    // One-cycle read; data stands only in the cycle after the strobe
    task automatic bus_read(input usb_irq_pkg::addr_type a, output usb_irq_pkg::word_type d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        @(posedge mclk);
        d = reg_rdata;
    endtask : bus_read

    // Selection is written before any indexed access and never shares a target
    task automatic select_endpoint(input logic [3:0] num, input logic dir, input logic setup);
        logic s;
        s = (num == 4'h0) ? setup : 1'b0;
        bus_write(8'h2c, {26'h0, s, num, dir});
    endtask : select_endpoint
endmodule : mcu_model

// [dv/testbench.sv]
// Self-checking bench for the enable and select bank
`timescale 1ns/1ns
`include "usb_irq_params.svh"
module testbench;
    logic                  mclk;
    logic                  rst_n;
    usb_irq_pkg::addr_type reg_addr;
    usb_irq_pkg::word_type reg_wdata;
    logic                  reg_wr;
    logic                  reg_rd;
    usb_irq_pkg::word_type reg_rdata;
    logic                  usb_bus_reset;
    usb_irq_pkg::word_type irq_source_event;
    usb_irq_pkg::word_type irq_source_enable;
    logic                  global_irq_enable;
    logic                  irq_out;
    logic [3:0]            endpoint_number;
    logic                  endpoint_dir;
    logic                  setup_buffer_select;
    logic [6:0]            data_out_irq_en;
    logic [6:0]            data_in_irq_en;
    logic                  ctrl_in_irq_en, ctrl_out_irq_en, ctrl_setup_irq_en;
    logic                  supply_sense_irq_en, transfer_engine_irq_en, speed_change_irq_en;
    logic                  wakeup_irq_en, sleep_irq_en, synthetic_frame_irq_en;
    logic                  frame_start_irq_en, bus_reset_irq_en;
    int                    bad_count;
    int                    compares;

    usb_irq_enable_endpoint_select u_usb_irq_enable_endpoint_select
    (
        .mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .usb_bus_reset,
        .irq_source_event, .irq_source_enable, .global_irq_enable, .irq_out,
        .endpoint_number, .endpoint_dir, .setup_buffer_select, .data_out_irq_en,
        .data_in_irq_en, .ctrl_in_irq_en, .ctrl_out_irq_en, .ctrl_setup_irq_en,
        .supply_sense_irq_en, .transfer_engine_irq_en, .speed_change_irq_en, .wakeup_irq_en,
        .sleep_irq_en, .synthetic_frame_irq_en, .frame_start_irq_en, .bus_reset_irq_en
    );

    mcu_model u_mcu_model
    (
        .mclk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata
    );

    // Clock of 4 ns period
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic check(input usb_irq_pkg::word_type seen, input usb_irq_pkg::word_type exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done();
        if (bad_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    // Let the updates of the last edge land before looking at outputs
    task automatic settle();
        @(posedge mclk);
        #1;
    endtask : settle

    task automatic pulse(input usb_irq_pkg::word_type e);
        @(posedge mclk);
        irq_source_event <= e;
        @(posedge mclk);
        irq_source_event <= 32'h00000000;
        settle();
        settle();
    endtask : pulse

    // Rebuild the mask from the per-source outputs so a miswired field shows up
    function automatic usb_irq_pkg::word_type pack_en();
        usb_irq_pkg::word_type w;
        w = 32'h00000000;
        for (int k = 0; k < 7; k++)
        begin
            w[12 + 2 * k] = data_out_irq_en[k];
            w[13 + 2 * k] = data_in_irq_en[k];
        end
        w[11:10] = {ctrl_in_irq_en, ctrl_out_irq_en};
        w[8:0]   = {ctrl_setup_irq_en, supply_sense_irq_en, transfer_engine_irq_en,
                    speed_change_irq_en, wakeup_irq_en, sleep_irq_en,
                    synthetic_frame_irq_en, frame_start_irq_en, bus_reset_irq_en};
        return w;
    endfunction : pack_en

    // Watchdog: the sequence needs well under 1000 cycles
    initial
    begin
        #40000;
        bad_count++;
        test_done();
    end

    // Main sequence
    initial
    begin
        usb_irq_pkg::word_type d;
        usb_irq_pkg::word_type e;
        logic [7:0]            sel_val [4];
        sel_val          = '{8'h1f, 8'h20, 8'he0, 8'h01};
        bad_count        = 0;
        compares         = 0;
        rst_n            = 1'b0;
        usb_bus_reset    = 1'b0;
        irq_source_event = 32'h00000000;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        u_mcu_model.bus_read(`IEN_OFFSET, d);
        check(d, 32'h00000000);
        u_mcu_model.bus_read(`EPS_OFFSET, d);
        check(d, 32'h00000000);
        // Walking one over the whole mask, reserved places included
        for (int i = 0; i < 32; i++)
        begin
            e = (32'h00000001 << i) & 32'h03fffdff;
            u_mcu_model.bus_write(`IEN_OFFSET, 32'h00000001 << i);
            settle();
            check(pack_en(), e);
            check(irq_source_enable, e);
            u_mcu_model.bus_read(`IEN_OFFSET, d);
            check(d, e);
        end
        u_mcu_model.select_endpoint(4'h1, 1'b0, 1'b1);
        settle();
        check({26'h0, setup_buffer_select, endpoint_number, endpoint_dir}, 32'h02);
        for (int i = 0; i < 4; i++)
        begin
            u_mcu_model.bus_write(`EPS_OFFSET, {24'h0, sel_val[i]});
            settle();
            check({26'h0, setup_buffer_select, endpoint_number, endpoint_dir},
                  {26'h0, sel_val[i][5:0]});
            u_mcu_model.bus_read(`EPS_OFFSET, d);
            check(d, {26'h0, sel_val[i][5:0]});
        end
        // Unmapped place: write dropped, read zero
        u_mcu_model.bus_write(8'h30, 32'hffffffff);
        u_mcu_model.bus_read(8'h30, d);
        check(d, 32'h00000000);
        // Bus reset keeps only the bus reset enable
        u_mcu_model.bus_write(`IEN_OFFSET, 32'hffffffff);
        @(posedge mclk);
        usb_bus_reset <= 1'b1;
        @(posedge mclk);
        usb_bus_reset <= 1'b0;
        settle();
        check(pack_en(), 32'h00000001);
        check({31'h0, setup_buffer_select | (|endpoint_number) | endpoint_dir}, 32'h0);
        u_mcu_model.bus_write(`IEN_OFFSET, 32'h00000002);
        @(posedge mclk);
        usb_bus_reset <= 1'b1;
        @(posedge mclk);
        usb_bus_reset <= 1'b0;
        settle();
        check(irq_source_enable, 32'h00000000);
        // Interrupt path: enabled, globally gated, masked, cleared
        u_mcu_model.bus_write(`MODE_OFFSET, 32'h00000001);
        u_mcu_model.bus_write(`IEN_OFFSET, 32'h00000002);
        pulse(32'h00000002);
        check({31'h0, irq_out}, 32'h1);
        check({31'h0, global_irq_enable}, 32'h1);
        u_mcu_model.bus_read(`STS_OFFSET, d);
        check(d, 32'h00000002);
        u_mcu_model.bus_read(`MODE_OFFSET, d);
        check(d, 32'h00000001);
        u_mcu_model.bus_write(`MODE_OFFSET, 32'h00000000);
        settle();
        settle();
        check({31'h0, irq_out}, 32'h0);
        u_mcu_model.bus_write(`MODE_OFFSET, 32'h00000001);
        settle();
        settle();
        check({31'h0, irq_out}, 32'h1);
        u_mcu_model.bus_write(`STS_OFFSET, 32'h00000002);
        u_mcu_model.bus_write(`IEN_OFFSET, 32'h00000000);
        pulse(32'h00000008);
        check({31'h0, irq_out}, 32'h0);
        u_mcu_model.bus_write(`IEN_OFFSET, 32'h00000008);
        settle();
        settle();
        check({31'h0, irq_out}, 32'h1);
        u_mcu_model.bus_write(`STS_OFFSET, 32'hffffffff);
        u_mcu_model.bus_write(`IEN_OFFSET, 32'hffffffff);
        pulse(32'hfc000200);
        check({31'h0, irq_out}, 32'h0);
        // Second hardware reset in mid-run clears everything again
        u_mcu_model.bus_write(`EPS_OFFSET, 32'h0000001f);
        @(posedge mclk);
        rst_n <= 1'b0;
        @(posedge mclk);
        rst_n <= 1'b1;
        settle();
        check({irq_source_enable[31:1], global_irq_enable}, 32'h0);
        check({26'h0, setup_buffer_select, endpoint_number, endpoint_dir}, 32'h0);
        test_done();
    end
endmodule : testbench
